// >>> core/vkr_params.svh
// Purpose: constants for the virtual k-clock resampler
// Assumes: samples of both channels arrive together on clk
// Notes:   counts are in sample clocks of 4 ns
// Functional notes
// (RULE_01) a rising edge is an upward pass of channel two through the threshold
// (RULE_02) the first sample after the crossing marks the edge position
// (RULE_03) the detector sample at that index is output, one per edge
// (RULE_04) optional linear interpolation places the edge finer than one sample
// (RULE_05) edges of pulses below a minimum amplitude are discarded, no output
// (RULE_06) each output carries the raw sample number of its edge
// (RULE_07) outputs are indexed by accepted edge count, not by time
// (RULE_08) the acquisition path delivers both channels in lockstep on one clock
`ifndef VKR_PARAMS_SVH
`define VKR_PARAMS_SVH
`define VKR_SAMPLE_W   16
`define VKR_INDEX_W    32
`define VKR_FRAC_W     8
`define VKR_CLK_PS     4000
`define VKR_RES_PS     100
// fraction steps needed for the target resolution, rounded up
`define VKR_FRAC_MIN   ((`VKR_CLK_PS + `VKR_RES_PS - 1) / `VKR_RES_PS)
`define VKR_BUF_DEPTH  2
`endif

// >>> core/vkr_pkg.sv
// Purpose: shared types of the resampler
// Assumes: vkr_params.svh constants
// Notes:   none
`include "vkr_params.svh"
package vkr_pkg;
    typedef logic signed [`VKR_SAMPLE_W-1:0] vkr_sample_t;
    typedef logic [`VKR_INDEX_W-1:0]         vkr_index_t;
    typedef logic [`VKR_FRAC_W-1:0]          vkr_frac_t;
    typedef struct packed {
        vkr_sample_t value;
        vkr_index_t  rawIndex;
        vkr_index_t  edgeCount;
        vkr_frac_t   frac;
    } vkr_word_t;
    typedef enum logic [0:0] {VKR_IDLE, VKR_PULSE} vkr_state_t;
endpackage

// >>> core/vkr_buf_if.sv
// Purpose: valid/ready carrier between resampler and its buffer
// Assumes: single clock
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
interface vkr_buf_if;
    import vkr_pkg::*;
    logic      valid;
    logic      ready;
    vkr_word_t data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> core/vkr_buf.sv
// Purpose: two-entry skid buffer on the output stream
// Assumes: synchronous active-low reset
// Notes:   output data and valid come from flip-flops
`timescale 1ns/10ps
`default_nettype none
`include "vkr_params.svh"
module vkr_buf (
    input  wire logic         clk,
    input  wire logic         nrst,
    vkr_buf_if.snk            inp,
    output var  logic         outValid,
    output var  vkr_pkg::vkr_word_t outData,
    input  wire logic         outReady
);
    import vkr_pkg::*;
    // ****************************************
    // storage
    // ****************************************
    vkr_word_t mem_r [`VKR_BUF_DEPTH];
    vkr_word_t mem_nxt [`VKR_BUF_DEPTH];
    logic [1:0] cnt_r, cnt_nxt;
    logic push, pop;
    logic headValid_r, headValid_nxt;
    // head entry is mem_r[0]; a word is never dropped on a stall
    assign inp.ready = (cnt_r != 2'h2);
    assign push = inp.valid && inp.ready;
    assign pop  = (cnt_r != 2'h0) && outReady;
    always_comb begin
        mem_nxt = mem_r;
        cnt_nxt = cnt_r;
        if (pop) begin
            mem_nxt[0] = mem_r[1];
        end
        if (push) begin
            if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) begin
                mem_nxt[0] = inp.data;
            end else if (pop) begin
                mem_nxt[0] = mem_r[1];
                mem_nxt[1] = inp.data;
            end else begin
                mem_nxt[1] = inp.data;
            end
        end
        cnt_nxt = 2'(cnt_r + {1'b0, push} - {1'b0, pop});
        headValid_nxt = (cnt_nxt != 2'h0);
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_r    <= 2'h0;
            headValid_r <= 1'b0;
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            headValid_r <= headValid_nxt;
            mem_r <= mem_nxt;
        end
    end
    assign outValid = headValid_r;
    assign outData  = mem_r[0];
    a_buf_nolose: assert property (@(posedge clk) disable iff (!nrst)
        outValid && !outReady |=> outValid && $stable(outData))
        else $error("buffer lost head word under stall");
    a_buf_full: assert property (@(posedge clk) disable iff (!nrst)
        cnt_r == 2'h2 && !outReady |=> cnt_r == 2'h2 && $stable(mem_r[1]))
        else $error("full buffer changed under stall");
endmodule
`default_nettype wire

// >>> core/vkr_resampler.sv
// Purpose: virtual k-clock resampling of a detector channel
// Assumes: both channels valid together on any clk with inValid high
// Notes:   one output word per accepted fringe-clock edge
`timescale 1ns/10ps
`default_nettype none
`include "vkr_params.svh"
module vkr_resampler #(
    parameter int SAMPLE_W = `VKR_SAMPLE_W
) (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               inValid,
    input  wire vkr_pkg::vkr_sample_t detSample,
    input  wire vkr_pkg::vkr_sample_t kclkSample,
    input  wire vkr_pkg::vkr_sample_t threshold,
    input  wire vkr_pkg::vkr_sample_t minAmplitude,
    input  wire logic               rejectEnable,
    input  wire logic               interpEnable,
    input  wire logic               frameStart,
    output logic                    inReady,
    output logic                    outValid,
    output vkr_pkg::vkr_word_t      outData,
    input  wire logic               outReady,
    output logic                    dropPulse
);
    import vkr_pkg::*;
    // ****************************************
    // edge detection and pulse tracking
    // ****************************************
    vkr_buf_if bif ();
    vkr_sample_t prevK_r, prevK_nxt;
    vkr_sample_t peak_r, peak_nxt;
    vkr_index_t  sampleNo_r, sampleNo_nxt;
    vkr_index_t  edgeCnt_r, edgeCnt_nxt;
    vkr_state_t  state_r, state_nxt;
    vkr_word_t   pend_r, pend_nxt;
    logic        pendV_r, pendV_nxt;
    logic        haveK_r, haveK_nxt;
    logic        stv_r, stv_nxt;
    vkr_word_t   stw_r, stw_nxt;
    logic        drop_r, drop_nxt;
    logic        inReady_r, inReady_nxt;
    logic [1:0]  bufCnt_r, bufCnt_nxt;
    logic        bufPush, bufPop;
    logic        take, rising, falling, accept;
    logic signed [SAMPLE_W:0] num, den;
    logic [`VKR_FRAC_W+SAMPLE_W:0] quot;
    // stall the source whenever the stage slot cannot drain
    // ready leaves a flip-flop, fed by a mirror of the buffer fill count
    assign bufPush = stv_r && (bufCnt_r != 2'h2);
    assign bufPop  = (bufCnt_r != 2'h0) && outReady;
    assign inReady = inReady_r;
    assign take    = inValid && inReady;
    // upward pass through the threshold [RULE_01]
    assign rising  = haveK_r && (prevK_r < threshold) && (kclkSample >= threshold);
    assign falling = (kclkSample < threshold);
    // pulse must reach threshold plus minimum before it ends [RULE_05]
    assign accept  = !rejectEnable ||
                     ((SAMPLE_W+1)'(peak_r) - (SAMPLE_W+1)'(threshold) >=
                      (SAMPLE_W+1)'(minAmplitude));
    // fraction of the sample period before the marked sample [RULE_04]
    assign num  = (SAMPLE_W+1)'(kclkSample) - (SAMPLE_W+1)'(threshold);
    assign den  = (SAMPLE_W+1)'(kclkSample) - (SAMPLE_W+1)'(prevK_r);
    assign quot = (den == '0) ? '0 :
                  (`VKR_FRAC_W+SAMPLE_W+1)'(({{`VKR_FRAC_W{1'b0}}, num} << `VKR_FRAC_W)
                  / {{`VKR_FRAC_W{1'b0}}, den});
    always_comb begin
        prevK_nxt    = prevK_r;
        peak_nxt     = peak_r;
        sampleNo_nxt = sampleNo_r;
        edgeCnt_nxt  = edgeCnt_r;
        state_nxt    = state_r;
        pend_nxt     = pend_r;
        pendV_nxt    = pendV_r;
        haveK_nxt    = haveK_r;
        stv_nxt      = stv_r && !bif.ready;
        stw_nxt      = stw_r;
        drop_nxt     = 1'b0;
        if (take) begin
            prevK_nxt    = kclkSample;
            haveK_nxt    = 1'b1;
            sampleNo_nxt = sampleNo_r + 1'b1;
            unique case (state_r)
                VKR_IDLE: begin
                    if (rising) begin
                        // mark the first sample after crossing [RULE_02]
                        state_nxt          = VKR_PULSE;
                        peak_nxt           = kclkSample;
                        pend_nxt.value     = detSample;        // [RULE_03]
                        pend_nxt.rawIndex  = sampleNo_r;       // [RULE_06]
                        pend_nxt.frac      = interpEnable ?
                            `VKR_FRAC_W'(quot) : '0;           // [RULE_04]
                        pendV_nxt          = 1'b1;
                    end
                end
                VKR_PULSE: begin
                    if (kclkSample > peak_r) begin
                        peak_nxt = kclkSample;
                    end
                    if (falling) begin
                        state_nxt = VKR_IDLE;
                        pendV_nxt = 1'b0;
                        if (accept) begin
                            // sequence index is accepted edge count [RULE_07]
                            stw_nxt           = pend_r;
                            stw_nxt.edgeCount = edgeCnt_r;
                            stv_nxt           = 1'b1;
                            edgeCnt_nxt       = edgeCnt_r + 1'b1;
                        end else begin
                            drop_nxt = 1'b1;           // [RULE_05]
                        end
                    end
                end
            endcase
        end
        if (frameStart) begin
            sampleNo_nxt = '0;
            edgeCnt_nxt  = '0;
            state_nxt    = VKR_IDLE;
            pendV_nxt    = 1'b0;
            haveK_nxt    = 1'b0;
        end
        bufCnt_nxt  = 2'(bufCnt_r + {1'b0, bufPush} - {1'b0, bufPop});
        inReady_nxt = !stv_nxt || (bufCnt_nxt != 2'h2);
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            prevK_r    <= '0;
            peak_r     <= '0;
            sampleNo_r <= '0;
            edgeCnt_r  <= '0;
            state_r    <= VKR_IDLE;
            pend_r     <= '0;
            pendV_r    <= 1'b0;
            haveK_r    <= 1'b0;
            stv_r      <= 1'b0;
            stw_r      <= '0;
            drop_r     <= 1'b0;
            bufCnt_r   <= 2'h0;
            inReady_r  <= 1'b1;
        end else begin
            prevK_r    <= prevK_nxt;
            peak_r     <= peak_nxt;
            sampleNo_r <= sampleNo_nxt;
            edgeCnt_r  <= edgeCnt_nxt;
            state_r    <= state_nxt;
            pend_r     <= pend_nxt;
            pendV_r    <= pendV_nxt;
            haveK_r    <= haveK_nxt;
            stv_r      <= stv_nxt;
            stw_r      <= stw_nxt;
            drop_r     <= drop_nxt;
            bufCnt_r   <= bufCnt_nxt;
            inReady_r  <= inReady_nxt;
        end
    end
    assign bif.valid = stv_r;
    assign bif.data  = stw_r;
    assign dropPulse = drop_r;
    // ****************************************
    // output buffer
    // ****************************************
    // lockstep channels let one index serve both [RULE_08]
    vkr_buf u_buf (
        .clk      (clk),
        .nrst     (nrst),
        .inp      (bif),
        .outValid (outValid),
        .outData  (outData),
        .outReady (outReady)
    );
    a_edge_mark: assert property (@(posedge clk) disable iff (!nrst)
        take && !frameStart && state_r == VKR_IDLE && rising
        |=> pendV_r && pend_r.rawIndex == $past(sampleNo_r)) // [RULE_02]
        else $error("edge not marked at crossing sample");
    a_det_pick: assert property (@(posedge clk) disable iff (!nrst)
        take && !frameStart && state_r == VKR_IDLE && rising
        |=> pend_r.value == $past(detSample)) // [RULE_03]
        else $error("wrong detector sample picked");
    a_no_edge: assert property (@(posedge clk) disable iff (!nrst)
        take && state_r == VKR_IDLE && !rising |=> !pendV_r) // [RULE_01]
        else $error("edge marked without upward crossing");
    a_reject_drop: assert property (@(posedge clk) disable iff (!nrst)
        take && !frameStart && state_r == VKR_PULSE && falling && !accept
        |=> dropPulse && edgeCnt_r == $past(edgeCnt_r)) // [RULE_05]
        else $error("weak pulse not dropped");
    a_count_seq: assert property (@(posedge clk) disable iff (!nrst)
        take && !frameStart && state_r == VKR_PULSE && falling && accept
        |=> stv_r && stw_r.edgeCount == $past(edgeCnt_r)
            && edgeCnt_r == $past(edgeCnt_r) + 1) // [RULE_07]
        else $error("edge count not sequential");
    a_raw_index: assert property (@(posedge clk) disable iff (!nrst)
        take && !frameStart && state_r == VKR_PULSE && falling && accept
        |=> stw_r.rawIndex == $past(pend_r.rawIndex)) // [RULE_06]
        else $error("raw sample number lost");
    a_interp_off: assert property (@(posedge clk) disable iff (!nrst)
        take && !frameStart && state_r == VKR_IDLE && rising && !interpEnable
        |=> pend_r.frac == '0) // [RULE_04]
        else $error("fraction set with interpolation off");
    a_stall_hold: assert property (@(posedge clk) disable iff (!nrst)
        stv_r && !bif.ready |=> stv_r && $stable(stw_r))
        else $error("stage word lost under stall");
    // ****************************************
    // further checks
    // ****************************************
    a_ready_mirror: assert property (@(posedge clk) disable iff (!nrst)
        inReady == (!stv_r || bif.ready))
        else $error("registered ready differs from stage and buffer state");
    a_first_sample: assert property (@(posedge clk) disable iff (!nrst)
        take && !frameStart && !haveK_r |=> !pendV_r) // [RULE_01]
        else $error("edge marked on first sample of a frame");
    a_drop_once: assert property (@(posedge clk) disable iff (!nrst)
        dropPulse |=> !dropPulse) // [RULE_05]
        else $error("drop pulse longer than one cycle");
    a_word_value: assert property (@(posedge clk) disable iff (!nrst)
        take && !frameStart && state_r == VKR_PULSE && falling && accept
        |=> stw_r.value == $past(pend_r.value)) // [RULE_03]
        else $error("detector sample lost at pulse end");
    a_sample_count: assert property (@(posedge clk) disable iff (!nrst)
        take && !frameStart |=> sampleNo_r == $past(sampleNo_r) + 1) // [RULE_06]
        else $error("raw sample number skipped");
    a_frame_clear: assert property (@(posedge clk) disable iff (!nrst)
        frameStart
        |=> sampleNo_r == '0 && edgeCnt_r == '0 && state_r == VKR_IDLE) // [RULE_07]
        else $error("frame start did not clear counts");
endmodule
`default_nettype wire

// >>> tb/vkr_adc_model.sv
// Purpose: dual-channel acquisition source for the resampler
// Assumes: bench fills the pair queues; pairs move on inReady
// Notes:   idle lines toggle so stale data never looks valid
`timescale 1ns/10ps
`default_nettype none
module vkr_adc_model (
    input  wire logic           clk,
    input  wire logic           nrst,
    input  wire logic           inReady,
    output var  logic           inValid,
    output var  vkr_pkg::vkr_sample_t detSample,
    output var  vkr_pkg::vkr_sample_t kclkSample
);
    import vkr_pkg::*;
    vkr_sample_t qd[$];
    vkr_sample_t qk[$];
    initial begin
        inValid = 1'b0;
        detSample = 16'h0000;
        kclkSample = 16'h0000;
    end
    // both channels leave together, one pair per take
    always @(posedge clk) begin
        if (nrst && inValid && inReady) begin
            void'(qd.pop_front());
            void'(qk.pop_front());
        end
    end
    always @(negedge clk) begin
        if (qd.size() > 0) begin
            inValid <= 1'b1;
            detSample <= qd[0];
            kclkSample <= qk[0];
        end else begin
            inValid <= 1'b0;
            detSample <= ~detSample;
            kclkSample <= ~kclkSample;
        end
    end
endmodule
`default_nettype wire

// >>> tb/test_virtual_kclock_resampler.sv
// Purpose: self-checking bench of the resampler
// Assumes: inputs change on falling edges
// Notes:   expected words come from a reference kept here
`timescale 1ns/10ps
`default_nettype none
module test_virtual_kclock_resampler;
    import vkr_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, frameStart = 1'b0, outReady = 1'b1;
    logic        rejectEnable = 1'b0, interpEnable = 1'b1;
    logic        inValid, inReady, outValid, dropPulse;
    vkr_sample_t threshold = 16'h0000, minAmplitude = 16'h0000;
    vkr_sample_t detSample, kclkSample;
    vkr_word_t   outData, pend;
    vkr_word_t   expQ[$], gotQ[$];
    int          mismatches = 0, samplesChecked = 0;
    int          idx, prevK, peak, edges, drops, seenDrops;
    bit          first, inPulse;
    always #2 clk = ~clk;
    vkr_adc_model adc (.clk(clk), .nrst(nrst), .inReady(inReady), .inValid(inValid),
        .detSample(detSample), .kclkSample(kclkSample));
    vkr_resampler dut (.clk(clk), .nrst(nrst), .inValid(inValid), .detSample(detSample),
        .kclkSample(kclkSample), .threshold(threshold), .minAmplitude(minAmplitude),
        .rejectEnable(rejectEnable), .interpEnable(interpEnable), .frameStart(frameStart),
        .inReady(inReady), .outValid(outValid), .outData(outData), .outReady(outReady),
        .dropPulse(dropPulse));
    always @(posedge clk) begin
        if (outValid === 1'b1 && outReady) gotQ.push_back(outData);
        if (dropPulse === 1'b1) seenDrops++;
    end
    // ****************
    // shared tasks
    // ****************
    task automatic check(string what, logic [79:0] seen, logic [79:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // reference: edge on upward pass, word emitted at pulse end
    task automatic feed(int k);
        int d, th;
        d = 100 + idx * 3;
        th = int'(threshold);
        adc.qd.push_back(vkr_sample_t'(d));
        adc.qk.push_back(vkr_sample_t'(k));
        if (!first && prevK < th && k >= th) begin
            inPulse = 1;
            peak = k;
            pend.value = vkr_sample_t'(d);
            pend.rawIndex = 32'(idx);
            pend.frac = interpEnable ? 8'(((k - th) * 256) / (k - prevK)) : 8'h00;
        end else if (inPulse && k >= th) begin
            peak = (k > peak) ? k : peak;
        end else if (inPulse) begin
            inPulse = 0;
            if (!rejectEnable || peak - th >= int'(minAmplitude)) begin
                pend.edgeCount = 32'(edges);
                expQ.push_back(pend);
                edges++;
            end else drops++;
        end
        first = 0;
        prevK = k;
        idx++;
    endtask
    // frameStart only while no pair is offered, so no take is lost
    task automatic frame();
        while (adc.qd.size() != 0) @(negedge clk);
        frameStart = 1'b1;
        @(negedge clk);
        frameStart = 1'b0;
        {idx, edges, drops, seenDrops, inPulse, first} = {32'd0, 32'd0, 32'd0, 32'd0, 2'b01};
        expQ.delete();
        gotQ.delete();
    endtask
    task automatic drain(string name);
        int n;
        n = 0;
        while ((adc.qd.size() != 0 || gotQ.size() < expQ.size()) && n < 200) begin
            @(negedge clk);
            n++;
        end
        repeat (10) @(negedge clk);
        check({name, " count"}, 80'(gotQ.size()), 80'(expQ.size()));
        foreach (expQ[i]) if (i < gotQ.size()) check({name, " word"}, gotQ[i], expQ[i]);
        check({name, " drops"}, 80'(seenDrops), 80'(drops));
        $display("test %s done", name);
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_walk();
        int ks[] = '{10, -5, 10, -3, 20, -4, 7, -1, 0, -2, 5, 9, -1};
        frame();
        foreach (ks[i]) feed(ks[i]);
        drain("walk");
    endtask
    task automatic t_reject();
        int ks[] = '{0, 120, -1, 0, 150, -1, 0, 130, 200, 90, 0, 149, 0};
        threshold = 16'h0064;
        minAmplitude = 16'h0032;
        rejectEnable = 1'b1;
        interpEnable = 1'b0;
        frame();
        foreach (ks[i]) feed(ks[i]);
        drain("reject");
        {rejectEnable, interpEnable, threshold} = {2'b01, 16'h0000};
    endtask
    task automatic t_stall();
        bit sawStall;
        sawStall = 0;
        frame();
        outReady = 1'b0;
        feed(-1);
        repeat (8) begin
            feed(5);
            feed(-1);
        end
        repeat (40) begin
            @(negedge clk);
            if (inReady === 1'b0) sawStall = 1;
        end
        check("stall inReady", 80'(sawStall), 80'(1));
        outReady = 1'b1;
        drain("stall");
    endtask
    // a pulse still open at frame start must not yield a word later
    task automatic t_cut();
        frame();
        feed(-1);
        feed(7);
        frame();
        feed(3);
        feed(-1);
        drain("cut");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        t_walk();
        t_reject();
        t_stall();
        t_cut();
        close_out();
    end
    // runs take about two hundred cycles; this is 5000 cycles, many times that
    initial begin
        #20000;
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire
